// ==== core/ddrcad_params.svh ====
// Purpose: constants of the command/address decoder
// Assumes: included once per compile unit
// Notes:   bit positions refer to the 48-bit command/address word
`ifndef DDRCAD_PARAMS_SVH
`define DDRCAD_PARAMS_SVH

// command/address field positions
`define DDRCAD_CA_W        48
`define DDRCAD_DIR_BIT     47
`define DDRCAD_SPACE_BIT   46
`define DDRCAD_BURST_BIT   45
`define DDRCAD_ROW_HI      44
`define DDRCAD_ROW_LO      16
`define DDRCAD_COL_HI      2
`define DDRCAD_COL_LO      0
// edges per command/address phase: three of each polarity
`define DDRCAD_CA_EDGES    2'h3
// base initial latency in link clock cycles and its doubling factor
`define DDRCAD_LAT_CYC     5'h06
`define DDRCAD_LAT_MULT    2
// reset values
`define DDRCAD_ADDR_RST    32'h0000_0000
`define DDRCAD_WORD_RST    16'h0000
`define DDRCAD_BYTE_RST    8'h00
`define DDRCAD_MASK_RST    2'h0

`endif

// ==== core/ddrcad_pkg.sv ====
// Purpose: types of the command/address decoder
// Assumes: nothing
// Notes:   phase codes are gray along command, latency, data
package ddrcad_pkg;
  typedef enum logic [1:0] {
    DDRCAD_PH_CA   = 2'h0,
    DDRCAD_PH_LAT  = 2'h1,
    DDRCAD_PH_DATA = 2'h3
  } ddrcad_phase_e;
  typedef logic [31:0] ddrcad_addr_t;
  typedef logic [15:0] ddrcad_word_t;
  typedef logic [7:0]  ddrcad_byte_t;
endpackage

// ==== core/ddrcad_decoder.sv ====
// Purpose: captures the 48-bit command/address sequence of a DDR byte bus,
//          decodes it, places word data on the bus for reads and takes it from the bus for writes
// Assumes: link clock comes from the host and may stop outside frames;
//          chip select high or hardware reset low ends the frame at once
// Notes:   array side of the data path runs on the link clock
//
// Behaviour
// - three words captured over six edges
// - bytes arrive MSB first, bit7 on line7
// - bit 47 set means read
// - bit 46 set means register space
// - bit 45 set means linear burst
// - bits 44..16 form address 31..3
// - reserved bits 15..3 are ignored
// - bits 2..0 form starting word address
// - half-page holds eight sixteen-bit words
// - access timing starts once row captured
// - linear burst runs across half-pages
// - each address selects one whole word
// - array bytes return where they were written
// - register space uses big-endian bytes
// - strobe toggles edge-aligned with read data
// - transfers never carry partial words
// - word per cycle, first byte strobe high
// - chip select rising ends the transaction
// - strobe signals latency during command phase
// - doubled latency always applied
// - reset low floats pins, reinitialises
`timescale 1ns/1ps
`include "ddrcad_params.svh"

module ddrcad_decoder (
  input  wire logic                  I_CLK,
  input  wire logic                  I_RST,
  input  wire logic                  I_LINK_CK,
  input  wire logic                  I_CS_N,
  input  wire logic                  I_RESET_N,
  input  wire logic [7:0]            I_DQ,
  output logic      [7:0]            O_DQ,
  output logic                       O_DQ_OE,
  input  wire logic                  I_READ_WRITE_STROBE,
  output logic                       O_READ_WRITE_STROBE,
  output logic                       O_READ_WRITE_STROBE_OE,
  output ddrcad_pkg::ddrcad_addr_t   O_RD_ADDR,
  input  wire ddrcad_pkg::ddrcad_word_t I_RD_DATA,
  output logic                       O_WR_VALID,
  output ddrcad_pkg::ddrcad_addr_t   O_WR_ADDR,
  output ddrcad_pkg::ddrcad_word_t   O_WR_DATA,
  output logic      [1:0]            O_WR_MASK,
  output logic                       O_CMD_VALID,
  output logic                       O_ACCESS_START,
  output logic                       O_READ,
  output logic                       O_SPACE_SELECT_BIT,
  output logic                       O_LINEAR,
  output ddrcad_pkg::ddrcad_addr_t   O_ADDR
);
  import ddrcad_pkg::*;

  localparam logic [4:0] LAT_END = 5'(`DDRCAD_LAT_CYC * `DDRCAD_LAT_MULT - 1);

  // ---------------- link clock domain ----------------
  logic                     link_rst;
  logic [1:0]               rise_cnt;
  logic [1:0]               fall_cnt;
  ddrcad_byte_t             ca_rise [0:2];
  ddrcad_byte_t             ca_fall [0:2];
  logic [`DDRCAD_CA_W-1:0]  command_address_word;
  logic                     ca_done;
  logic                     row_done;
  ddrcad_phase_e            phase;
  logic [4:0]               lat_cnt;
  ddrcad_addr_t             addr;
  ddrcad_addr_t             next_addr;
  ddrcad_addr_t             word_addr;
  logic                     data_seen;
  ddrcad_word_t             rd_word;
  ddrcad_byte_t             wr_hi;
  logic                     mask_hi;
  logic                     is_read;
  logic                     is_linear;

  // hazard: chip select is asynchronous to the link clock, so every link-side
  // register that must forget a frame takes it as an asynchronous clear
  // frame ends on chip select high or hardware reset low; clears the link side
  assign link_rst = I_CS_N | ~I_RESET_N;

  // bytes in capture order, most significant first
  assign command_address_word = {ca_rise[0], ca_fall[0], ca_rise[1],
                                 ca_fall[1], ca_rise[2], ca_fall[2]};
  assign is_read   = command_address_word[`DDRCAD_DIR_BIT];
  assign is_linear = command_address_word[`DDRCAD_BURST_BIT];

  // rising edges carry bytes 0, 2, 4; counters idle while clock stands low
  always_ff @(posedge I_LINK_CK or posedge link_rst) begin
    if (link_rst) begin
      rise_cnt <= 2'h0;
    end else if (rise_cnt != `DDRCAD_CA_EDGES) begin
      rise_cnt <= rise_cnt + 2'h1;
    end
  end

  // rising-edge byte store, bit 7 from line 7
  always_ff @(posedge I_LINK_CK) begin
    if (!link_rst && rise_cnt != `DDRCAD_CA_EDGES) begin
      ca_rise[rise_cnt] <= I_DQ;
    end
  end

  // falling edges carry bytes 1, 3, 5 and mark progress
  always_ff @(negedge I_LINK_CK or posedge link_rst) begin
    if (link_rst) begin
      fall_cnt <= 2'h0;
      row_done <= 1'b0;
      ca_done  <= 1'b0;
    end else if (fall_cnt != `DDRCAD_CA_EDGES) begin
      fall_cnt <= fall_cnt + 2'h1;
      if (fall_cnt == 2'h1) begin
        row_done <= 1'b1;  // bits 23..16 in: row and half-page known
      end
      if (fall_cnt == 2'h2) begin
        ca_done <= 1'b1;  // all 48 bits
      end
    end
  end

  // falling-edge byte store
  always_ff @(negedge I_LINK_CK) begin
    if (!link_rst && fall_cnt != `DDRCAD_CA_EDGES) begin
      ca_fall[fall_cnt] <= I_DQ;
    end
  end

  // next word: linear carries across half-pages, wrapped stays in eight words
  // the carry out of bit 2 is dropped on purpose for wrapped bursts
  always_comb begin
    if (is_linear) begin
      next_addr = addr + 32'h1;
    end else begin
      next_addr = {addr[31:3], addr[2:0] + 3'h1};
    end
  end

  // phase sequencer: command, doubled latency, data
  // the rising edge that leaves the command phase is not counted in lat_cnt
  always_ff @(posedge I_LINK_CK or posedge link_rst) begin
    if (link_rst) begin
      phase   <= DDRCAD_PH_CA;
      lat_cnt <= 5'h0;
    end else begin
      case (phase)
        DDRCAD_PH_CA: begin
          if (ca_done) begin
            phase <= DDRCAD_PH_LAT;
          end
        end
        DDRCAD_PH_LAT: begin
          lat_cnt <= lat_cnt + 5'h1;
          if (lat_cnt == LAT_END) begin
            phase <= DDRCAD_PH_DATA;
          end
        end
        default: begin
          phase <= DDRCAD_PH_DATA;
        end
      endcase
    end
  end

  // word address and per-cycle data handling on the rising edge
  always_ff @(posedge I_LINK_CK or posedge link_rst) begin
    if (link_rst) begin
      addr      <= `DDRCAD_ADDR_RST;
      word_addr <= `DDRCAD_ADDR_RST;
      data_seen <= 1'b0;
      rd_word   <= `DDRCAD_WORD_RST;
      wr_hi     <= `DDRCAD_BYTE_RST;
      mask_hi   <= 1'b0;
    end else if (phase == DDRCAD_PH_CA && ca_done) begin
      // reserved bits 15..3 take no part
      addr <= {command_address_word[`DDRCAD_ROW_HI:`DDRCAD_ROW_LO],
               command_address_word[`DDRCAD_COL_HI:`DDRCAD_COL_LO]};
    end else if (phase == DDRCAD_PH_DATA) begin
      word_addr <= addr;
      addr      <= next_addr;
      data_seen <= 1'b1;
      rd_word   <= I_RD_DATA;
      wr_hi     <= I_DQ;  // first byte of the word
      mask_hi   <= I_READ_WRITE_STROBE;
    end
  end

  assign O_RD_ADDR = addr;

  // write word completes on the falling edge; lone bytes never leave
  always_ff @(negedge I_LINK_CK or posedge link_rst) begin
    if (link_rst) begin
      O_WR_VALID <= 1'b0;
      O_WR_ADDR  <= `DDRCAD_ADDR_RST;
      O_WR_DATA  <= `DDRCAD_WORD_RST;
      O_WR_MASK  <= `DDRCAD_MASK_RST;
    end else if (phase == DDRCAD_PH_DATA && data_seen && !is_read) begin
      O_WR_VALID <= 1'b1;
      O_WR_ADDR  <= word_addr;
      O_WR_DATA  <= {wr_hi, I_DQ};  // first byte high
      O_WR_MASK  <= {mask_hi, I_READ_WRITE_STROBE};
    end else begin
      O_WR_VALID <= 1'b0;
    end
  end

  // read bytes: high byte while strobe high, low byte while strobe low
  // the mux follows the clock itself, so each byte is edge-aligned to the strobe
  assign O_DQ    = I_LINK_CK ? rd_word[15:8] : rd_word[7:0];
  assign O_DQ_OE = !link_rst && phase == DDRCAD_PH_DATA && data_seen
                   && is_read;

  // strobe: high during command/latency (doubled latency), clock-aligned on reads
  // it only starts to follow the clock with the first read word; toggling in
  // the half-cycle before would look like a latency strobe that drops early
  assign O_READ_WRITE_STROBE = (phase == DDRCAD_PH_DATA && data_seen) ? I_LINK_CK
                               : 1'b1;
  assign O_READ_WRITE_STROBE_OE = !link_rst &&
                                  (phase != DDRCAD_PH_DATA || is_read);

  // ---------------- system clock domain ----------------
  logic [2:0] rst_sync;
  logic [2:0] done_sync;
  logic [2:0] row_sync;
  logic       hw_rst;
  logic       done_lvl;
  logic       row_lvl;
  logic       sys_rst;

  // three-stage synchronisers; first stage feeds only the second
  always_ff @(posedge I_CLK) begin
    rst_sync  <= {rst_sync[1:0], ~I_RESET_N};
    done_sync <= {done_sync[1:0], ca_done};
    row_sync  <= {row_sync[1:0], row_done};
  end

  // agreed levels: change once stages two and three match
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      hw_rst   <= 1'b0;
      done_lvl <= 1'b0;
      row_lvl  <= 1'b0;
    end else begin
      if (rst_sync[1] == rst_sync[2]) begin
        hw_rst <= rst_sync[2];
      end
      if (done_sync[1] == done_sync[2]) begin
        done_lvl <= done_sync[2];
      end
      if (row_sync[1] == row_sync[2]) begin
        row_lvl <= row_sync[2];
      end
    end
  end

  assign sys_rst = I_RST | hw_rst;

  // access start pulse on row capture
  // one pulse per frame: the agreed level blocks a repeat while row_done stays high
  always_ff @(posedge I_CLK) begin
    if (sys_rst) begin
      O_ACCESS_START <= 1'b0;
    end else begin
      O_ACCESS_START <= row_sync[2] && !row_lvl && row_sync[1];
    end
  end

  // decode once the full word is held stable on the link side
  // the word is read across domains without a copy; chip select stays low
  // until the pulse, so the captured bytes cannot move under the decode
  always_ff @(posedge I_CLK) begin
    if (sys_rst) begin
      O_CMD_VALID        <= 1'b0;
      O_READ             <= 1'b0;
      O_SPACE_SELECT_BIT <= 1'b0;
      O_LINEAR           <= 1'b0;
      O_ADDR             <= `DDRCAD_ADDR_RST;
    end else begin
      O_CMD_VALID <= 1'b0;
      if (done_sync[2] && done_sync[1] && !done_lvl) begin
        O_CMD_VALID        <= 1'b1;
        O_READ             <= command_address_word[`DDRCAD_DIR_BIT];
        O_SPACE_SELECT_BIT <= command_address_word[`DDRCAD_SPACE_BIT];
        O_LINEAR           <= command_address_word[`DDRCAD_BURST_BIT];
        O_ADDR             <= {command_address_word[`DDRCAD_ROW_HI:`DDRCAD_ROW_LO],
                               command_address_word[`DDRCAD_COL_HI:`DDRCAD_COL_LO]};
      end
    end
  end

endmodule

// ==== dv/ddrcad_host.sv ====
// Purpose: host bus model: link clock, chip select, command bytes, data
// Assumes: clock stands low outside frames, 125 ns period
// Notes:   released lines show the inverse of their last value
`timescale 1ns/1ps
`include "ddrcad_params.svh"
module ddrcad_host (
  output logic            o_ck,
  output logic            o_cs_n,
  output logic [7:0]      o_dq,
  output logic            o_strobe,
  input  wire logic [7:0] i_dq,
  input  wire logic       i_dq_oe,
  input  wire logic       i_strobe
);
  localparam int LAT = `DDRCAD_LAT_CYC * `DDRCAD_LAT_MULT + 1;
  logic [15:0] wq[$];
  logic [1:0]  mq[$];
  logic [15:0] rq[$];
  // idle bus
  initial begin
    o_ck = 1'b0;
    o_cs_n = 1'b0;
    o_dq = 8'h00;
    o_strobe = 1'b0;
    #1 o_cs_n = 1'b1; // clean rising edge clears the link side once
  end
  // one clock edge with the byte centred on it
  task automatic edge_out(input logic [7:0] b, input logic s);
    o_dq = b;
    o_strobe = s;
    #31.25;
    o_ck = ~o_ck;
    #31.25;
  endtask
  // one frame: ne command edges, latency, then n words
  task automatic frame(input logic [47:0] ca, input int ne, input int n, output int bad);
    logic [15:0] w;
    logic        rd;
    rd = ca[47];
    bad = 0;
    o_cs_n = 1'b0;
    for (int i = 0; i < ne; i++) edge_out(ca[47 - 8 * i -: 8], 1'b0);
    for (int i = 0; i < 2 * LAT && ne == 6; i++) edge_out(~o_dq, 1'b0);
    for (int k = 0; k < n; k++) begin
      edge_out(rd ? ~o_dq : wq[k][15:8], rd ? 1'b0 : mq[k][1]);
      w[15:8] = i_dq;
      if (rd && (i_dq_oe !== 1'b1 || i_strobe !== 1'b1)) bad++;
      edge_out(rd ? ~o_dq : wq[k][7:0], rd ? 1'b0 : mq[k][0]);
      w[7:0] = i_dq;
      if (rd && i_strobe !== 1'b0) bad++;
      if (rd) rq.push_back(w);
    end
    #31.25;
    o_cs_n = 1'b1;
    o_dq = ~o_dq;
    wq.delete();
    mq.delete();
    #250; // chip select stays high long enough for the system side to see it
  endtask
endmodule

// ==== dv/ddrcad_decoder_assertions.sv ====
// Purpose: port checker for the command/address decoder
// Assumes: bound to the decoder top
// Notes:   link checks run on the host clock
`timescale 1ns/1ps
module ddrcad_decoder_assertions (
  input wire logic                     I_CLK,
  input wire logic                     I_RST,
  input wire logic                     I_LINK_CK,
  input wire logic                     I_CS_N,
  input wire logic                     I_RESET_N,
  input wire logic                     O_DQ_OE,
  input wire logic                     O_READ_WRITE_STROBE,
  input wire logic                     O_READ_WRITE_STROBE_OE,
  input wire ddrcad_pkg::ddrcad_addr_t O_RD_ADDR,
  input wire logic                     O_WR_VALID,
  input wire logic                     O_CMD_VALID,
  input wire logic                     O_ACCESS_START,
  input wire logic                     O_READ,
  input wire logic                     O_SPACE_SELECT_BIT,
  input wire logic                     O_LINEAR,
  input wire ddrcad_pkg::ddrcad_addr_t O_ADDR
);
  // low read address bits seen at the previous link edge
  logic [2:0] lo_q;
  always_ff @(posedge I_LINK_CK) lo_q <= O_RD_ADDR[2:0];
  property p_cmd_pulse;
    @(posedge I_CLK) disable iff (I_RST) O_CMD_VALID |=> !O_CMD_VALID;
  endproperty
  a_cmd_pulse: assert property (p_cmd_pulse) else $error("command pulse too long");
  property p_fields_hold;
    @(posedge I_CLK) disable iff (I_RST) !O_CMD_VALID && I_RESET_N
      |-> $stable({O_READ, O_SPACE_SELECT_BIT, O_LINEAR, O_ADDR});
  endproperty
  a_fields_hold: assert property (p_fields_hold) else $error("fields moved");
  property p_start_cmd;
    @(posedge I_CLK) disable iff (I_RST) O_ACCESS_START |-> ##[1:8] O_CMD_VALID;
  endproperty
  a_start_cmd: assert property (p_start_cmd) else $error("no command after start");
  property p_rst_float;
    @(posedge I_CLK) disable iff (I_RST) !I_RESET_N |-> !O_DQ_OE && !O_READ_WRITE_STROBE_OE;
  endproperty
  a_rst_float: assert property (p_rst_float) else $error("pins driven in reset");
  property p_cs_idle;
    @(posedge I_CLK) disable iff (I_RST)
      I_CS_N |-> !O_DQ_OE && !O_READ_WRITE_STROBE_OE && !O_WR_VALID;
  endproperty
  a_cs_idle: assert property (p_cs_idle) else $error("active outside frame");
  property p_strobe_ca;
    @(posedge I_CLK) disable iff (I_RST)
      O_READ_WRITE_STROBE_OE && !O_DQ_OE |-> O_READ_WRITE_STROBE;
  endproperty
  a_strobe_ca: assert property (p_strobe_ca) else $error("latency strobe low");
  property p_strobe_data;
    @(posedge I_CLK) disable iff (I_RST) O_DQ_OE |-> O_READ_WRITE_STROBE == I_LINK_CK;
  endproperty
  a_strobe_data: assert property (p_strobe_data) else $error("strobe not clock");
  property p_rd_step;
    @(posedge I_LINK_CK) disable iff (I_CS_N || !I_RESET_N)
      O_DQ_OE && $past(O_DQ_OE) |-> O_RD_ADDR[2:0] == lo_q + 3'h1;
  endproperty
  a_rd_step: assert property (p_rd_step) else $error("read address step");
endmodule
bind ddrcad_decoder ddrcad_decoder_assertions u_chk (.I_CLK, .I_RST, .I_LINK_CK, .I_CS_N,
  .I_RESET_N, .O_DQ_OE, .O_READ_WRITE_STROBE, .O_READ_WRITE_STROBE_OE, .O_RD_ADDR,
  .O_WR_VALID, .O_CMD_VALID, .O_ACCESS_START, .O_READ, .O_SPACE_SELECT_BIT, .O_LINEAR, .O_ADDR);

// ==== dv/tb.sv ====
// Purpose: self-checking bench for the command/address decoder
// Assumes: host model drives the link, bench plays the array
// Notes:   memories are indexed by the low six address bits
`timescale 1ns/1ps
module tb;
  import ddrcad_pkg::*;
  logic         clk, rst, rst_n, lk, cs_n, h_st;
  logic [7:0]   h_dq, dq_o;
  wire  [7:0]   dq_i;
  wire          st_i;
  logic         dq_oe, st_o, st_oe, wr_valid, cmd_valid, acc_start, rd, space, lin;
  ddrcad_addr_t rd_addr, wr_addr, addr, a, ea;
  ddrcad_word_t rd_data, wr_data, w;
  logic [1:0]   wr_mask, m;
  logic [47:0]  exp_ca;
  logic [49:0]  ew[$];
  ddrcad_word_t arr [64] = '{default: 16'h0};
  ddrcad_word_t mdl [64] = '{default: 16'h0};
  integer       seed = 67847;
  int           failures = 0;
  int           n_tests = 0;
  int           ncmd = 0;
  int           nacc = 0;
  int           n, c0, s0, bad;
  // resolved two-way lines and the array read port
  assign dq_i    = dq_oe ? dq_o : h_dq;
  assign st_i    = st_oe ? st_o : h_st;
  assign rd_data = arr[rd_addr[5:0]];
  ddrcad_decoder u_ddrcad_decoder (.I_CLK(clk), .I_RST(rst), .I_LINK_CK(lk), .I_CS_N(cs_n),
    .I_RESET_N(rst_n), .I_DQ(dq_i), .O_DQ(dq_o), .O_DQ_OE(dq_oe), .I_READ_WRITE_STROBE(st_i),
    .O_READ_WRITE_STROBE(st_o), .O_READ_WRITE_STROBE_OE(st_oe), .O_RD_ADDR(rd_addr),
    .I_RD_DATA(rd_data), .O_WR_VALID(wr_valid), .O_WR_ADDR(wr_addr), .O_WR_DATA(wr_data),
    .O_WR_MASK(wr_mask), .O_CMD_VALID(cmd_valid), .O_ACCESS_START(acc_start), .O_READ(rd),
    .O_SPACE_SELECT_BIT(space), .O_LINEAR(lin), .O_ADDR(addr));
  ddrcad_host u_ddrcad_host (.o_ck(lk), .o_cs_n(cs_n), .o_dq(h_dq), .o_strobe(h_st),
    .i_dq(dq_i), .i_dq_oe(dq_oe), .i_strobe(st_i));
  // compare, count and report
  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // burst address: wrapped bursts stay in their half-page
  function automatic ddrcad_addr_t nxt(input ddrcad_addr_t s, input int k, input logic l);
    return l ? s + 32'(k) : {s[31:3], s[2:0] + 3'(k)};
  endfunction
  // clock and watchdog
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    test_done;
  end
  // decoded command against the frame sent
  always @(posedge clk) begin
    if (acc_start === 1'b1) nacc++;
    if (cmd_valid === 1'b1) begin
      ncmd++;
      chk("cmd", {exp_ca[47:16], exp_ca[2:0]}, {rd, space, lin, addr});
    end
  end
  // write words against the model, then into the array
  always @(negedge lk) begin
    #5;
    if (wr_valid === 1'b1) begin
      chk("write", ew.pop_front(), {wr_addr, wr_data, wr_mask});
      arr[wr_addr[5:0]] = wr_data;
    end
  end
  // main sequence: every space and burst type, write then read back
  initial begin
    rst = 1'b1;
    rst_n = 1'b1;
    repeat (2) @(posedge clk);
    #1 rst = 1'b0;
    for (int i = 0; i < 8; i++) begin
      a = $random(seed);
      if (i[2]) a[31:6] = 26'h0; // 64-word model uses no higher row bits
      n = 1 + (i * 3) % 10;
      for (int d = 0; d < 2; d++) begin
        exp_ca = {d[0], i[0], i[1], a[31:3], 13'($random(seed)), a[2:0]};
        for (int k = 0; k < n && d == 0; k++) begin
          ea = nxt(a, k, i[1]);
          w = 16'($random(seed));
          m = 2'($random(seed));
          mdl[ea[5:0]] = w;
          ew.push_back({ea, w, m});
          u_ddrcad_host.wq.push_back(w);
          u_ddrcad_host.mq.push_back(m);
        end
        c0 = ncmd;
        s0 = nacc;
        u_ddrcad_host.frame(exp_ca, 6, n, bad);
        chk("strobe", 0, bad);
        chk("ncmd", c0 + 1, ncmd);
        chk("start", s0 + 1, nacc);
        for (int k = 0; k < n && d == 1; k++) begin
          ea = nxt(a, k, i[1]);
          chk("rdata", mdl[ea[5:0]], u_ddrcad_host.rq.pop_front());
        end
      end
    end
    @(posedge clk);
    #1 rst_n = 1'b0;
    repeat (6) @(posedge clk);
    chk("fields", 0, {rd, space, lin, addr});
    #1 rst_n = 1'b1;
    repeat (6) @(posedge clk);
    #1 c0 = ncmd;
    s0 = nacc;
    u_ddrcad_host.frame(exp_ca, 2, 0, bad);
    repeat (20) @(posedge clk);
    chk("abort", c0, ncmd);
    chk("abort start", s0, nacc);
    u_ddrcad_host.frame(exp_ca, 6, n, bad);
    chk("recover strobe", 0, bad);
    chk("recover", c0 + 1, ncmd);
    for (int k = 0; k < n; k++) begin
      ea = nxt(a, k, exp_ca[45]);
      chk("rdata", mdl[ea[5:0]], u_ddrcad_host.rq.pop_front());
    end
    chk("left", 0, ew.size());
    test_done;
  end
endmodule
